// ---- rtl/pcr_config_regs.v ----
`timescale 1ns/1ns
`include "pcr_consts.vh"
module pcr_config_regs (
  // clock and reset
  input wire clock_i,
  input wire rstn_i,
  // command and byte transfer port
  input wire txn_start_i,
  input wire [7:0] cmd_i,
  input wire wr_byte_valid_i,
  input wire [7:0] wr_byte_i,
  input wire rd_byte_req_i,
  output reg [7:0] rd_byte_o,
  output reg rd_byte_valid_o,
  output wire cmd_known_o,
  output reg wr_refused_o,
  // device side inputs
  input wire [15:0] strap_nominal_i,
  input wire [7:0] vout_mode_i,
  input wire [15:0] vout_command_i,
  input wire [1:0] margin_sel_i,
  input wire [15:0] vin_i,
  input wire [15:0] duty_request_i,
  input wire [15:0] vout_sense_i,
  input wire [15:0] cs_offset_i,
  // configuration outputs
  output reg [15:0] vout_target_o,
  output reg vout_linear_o,
  output reg [4:0] vout_exp_o,
  output reg [15:0] slew_rate_o,
  output reg [15:0] droop_o,
  output reg [15:0] loop_gain_o,
  output reg [15:0] mon_ratio_o,
  output reg [15:0] duty_o,
  output reg [15:0] switch_khz_o,
  output reg convert_en_o,
  output reg [3:0] group_id_o,
  output reg [3:0] rail_count_o,
  output reg [3:0] rail_pos_o,
  output reg [15:0] cs_offset_o,
  output reg ov_fault_o
);

  // word storage for the writable commands
  reg [15:0] regs_ff [0:`PCR_NUM_REGS-1];
  reg [7:0] cmd_ff; // command latched at transfer start
  reg byte_sel_ff; // 0 expects low byte, 1 expects high byte
  reg [7:0] low_ff; // low byte held until high byte arrives
  reg [15:0] strap_ff; // nominal setting caught after reset
  reg strap_taken_ff; // strap capture done
  reg running_ff; // conversion active
  integer i;

  // decoded command
  wire [4:0] idx_code; // writable flag over the storage index
  wire [3:0] cur_idx; // storage index of the latched command
  wire cur_rw; // latched command is a writable word
  wire cur_ro; // latched command is the read-only offset
  wire [15:0] wr_word; // high byte on the port over the held low byte
  // ceiling limit is kept wide so a large strap cannot wrap the product
  wire [23:0] ceil_limit_w;
  wire [15:0] ceil_limit; // saturated limit for ceiling writes
  wire [15:0] rd_word; // word behind the latched command
  wire signed [47:0] vin_fix;
  wire signed [47:0] start_fix;
  wire signed [47:0] stop_fix;
  wire signed [47:0] duty_req_fix;
  wire signed [47:0] duty_lim_fix;
  wire signed [47:0] freq_fix;

  // command code to storage index, bit 4 flags a writable word
  function [4:0] pcr_index;
    input [7:0] cmd;
    begin
      case (cmd)
        `PCR_CMD_CEILING: pcr_index = {1'b1, `PCR_IDX_CEILING};
        `PCR_CMD_MARGIN_UP: pcr_index = {1'b1, `PCR_IDX_MARGIN_UP};
        `PCR_CMD_MARGIN_DOWN: pcr_index = {1'b1, `PCR_IDX_MARGIN_DOWN};
        `PCR_CMD_SLEW: pcr_index = {1'b1, `PCR_IDX_SLEW};
        `PCR_CMD_DROOP: pcr_index = {1'b1, `PCR_IDX_DROOP};
        `PCR_CMD_LOOP_GAIN: pcr_index = {1'b1, `PCR_IDX_LOOP_GAIN};
        `PCR_CMD_MON_RATIO: pcr_index = {1'b1, `PCR_IDX_MON_RATIO};
        `PCR_CMD_DUTY: pcr_index = {1'b1, `PCR_IDX_DUTY};
        `PCR_CMD_FREQ: pcr_index = {1'b1, `PCR_IDX_FREQ};
        `PCR_CMD_VIN_START: pcr_index = {1'b1, `PCR_IDX_VIN_START};
        `PCR_CMD_VIN_STOP: pcr_index = {1'b1, `PCR_IDX_VIN_STOP};
        `PCR_CMD_PHASE: pcr_index = {1'b1, `PCR_IDX_PHASE};
        `PCR_CMD_OV_LIMIT: pcr_index = {1'b1, `PCR_IDX_OV_LIMIT};
        // unmapped codes and the read-only offset give zero
        default: pcr_index = 5'h00;
      endcase
    end
  endfunction

  // linear word to fixed point with 16 fraction bits
  function signed [47:0] pcr_lin_fix;
    input [15:0] word;
    reg signed [47:0] mant;
    reg [5:0] shift;
    begin
      mant = {{37{word[10]}}, word[10:0]};
      // exponent plus 16 is never negative, so a left shift suffices
      shift = {word[15], word[15:11]} + 6'h10;
      pcr_lin_fix = mant <<< shift;
    end
  endfunction

  // command decode, one lookup shared by index and flag
  assign idx_code = pcr_index(cmd_ff);
  // low four bits pick the word
  assign cur_idx = idx_code[3:0];
  // top bit marks a writable word
  assign cur_rw = idx_code[4];
  assign cur_ro = (cmd_ff == `PCR_CMD_CS_OFFSET);
  assign cmd_known_o = cur_rw | cur_ro;
  assign wr_word = {wr_byte_i, low_ff};

  // R1 ceiling limit 110%
  // the strap times 110 needs 23 bits; the floor of the division is kept
  assign ceil_limit_w = ({8'h00, strap_ff} * {4'h0, `PCR_CEIL_PCT_NUM}) /
    {4'h0, `PCR_CEIL_PCT_DEN};
  // a limit beyond the word width saturates at full scale
  assign ceil_limit = (ceil_limit_w[23:16] != 8'h00) ? 16'hffff : ceil_limit_w[15:0];

  // readback word, unknown command reads zero
  assign rd_word = cur_ro ? cs_offset_i : (cur_rw ? regs_ff[cur_idx] : 16'h0000);

  // R19 linear decode
  assign vin_fix = pcr_lin_fix(vin_i);
  assign start_fix = pcr_lin_fix(regs_ff[`PCR_IDX_VIN_START]);
  assign stop_fix = pcr_lin_fix(regs_ff[`PCR_IDX_VIN_STOP]);
  assign duty_req_fix = pcr_lin_fix(duty_request_i);
  assign duty_lim_fix = pcr_lin_fix(regs_ff[`PCR_IDX_DUTY]);
  assign freq_fix = pcr_lin_fix(regs_ff[`PCR_IDX_FREQ]);

  // strap is caught on the first edge after reset release
  // a strap change after that takes effect only at the next reset
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_ff <= 16'h0000;
      strap_taken_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_ff <= strap_nominal_i;
      strap_taken_ff <= 1'b1;
    end
  end

  // byte sequencing and register writes
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_ff <= 8'h00;
      byte_sel_ff <= 1'b0;
      low_ff <= 8'h00;
      rd_byte_o <= 8'h00;
      rd_byte_valid_o <= 1'b0;
      wr_refused_o <= 1'b0;
      // every writable word clears to its reset value
      for (i = 0; i < `PCR_NUM_REGS; i = i + 1) begin
        regs_ff[i] <= `PCR_RESET_WORD;
      end
    end else begin
      // both strobes last one cycle unless set again below
      rd_byte_valid_o <= 1'b0;
      wr_refused_o <= 1'b0;
      // a transfer start wins over any byte in the same cycle
      if (txn_start_i) begin
        // new transfer restarts at the low byte
        cmd_ff <= cmd_i;
        byte_sel_ff <= 1'b0;
      end else if (wr_byte_valid_i) begin
        // R20 low byte first
        if (!byte_sel_ff) begin
          low_ff <= wr_byte_i;
          byte_sel_ff <= 1'b1;
        end else begin
          byte_sel_ff <= 1'b0;
          if (cur_ro) begin
            // R20 offset write refused
            wr_refused_o <= 1'b1;
          end else if (cur_rw) begin
            // only mapped words are stored; unmapped writes are dropped
            if (cur_idx == `PCR_IDX_CEILING && wr_word > ceil_limit) begin
              // R1 clamp to limit
              regs_ff[cur_idx] <= ceil_limit;
            end else begin
              // R17 plain word store
              regs_ff[cur_idx] <= wr_word;
            end
          end
        end
      end else if (rd_byte_req_i) begin
        // R20 read low then high
        rd_byte_valid_o <= 1'b1;
        byte_sel_ff <= ~byte_sel_ff;
        // pointer picks which half goes out
        if (!byte_sel_ff) begin
          rd_byte_o <= rd_word[7:0];
        end else begin
          rd_byte_o <= rd_word[15:8];
        end
      end
    end
  end

  // conversion enable with start and stop thresholds
  // the stop level acts only while running, which gives hysteresis
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      running_ff <= 1'b0;
    end else if (!running_ff) begin
      // stopped: wait for the input to reach the start level
      // R10 start at threshold
      if (vin_fix >= start_fix) begin
        running_ff <= 1'b1;
      end
    end else begin
      // R11 stop at threshold
      if (vin_fix <= stop_fix) begin
        running_ff <= 1'b0;
      end
    end
  end

  // registered configuration outputs
  // every output follows its source one cycle later
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vout_target_o <= 16'h0000;
      vout_linear_o <= 1'b0;
      vout_exp_o <= 5'h00;
      slew_rate_o <= 16'h0000;
      droop_o <= 16'h0000;
      loop_gain_o <= 16'h0000;
      mon_ratio_o <= 16'h0000;
      duty_o <= 16'h0000;
      switch_khz_o <= 16'h0000;
      convert_en_o <= 1'b0;
      group_id_o <= 4'h0;
      rail_count_o <= 4'h0;
      rail_pos_o <= 4'h0;
      cs_offset_o <= 16'h0000;
      ov_fault_o <= 1'b0;
    end else begin
      // margin targets bypass the ceiling; the nominal path does not
      case (margin_sel_i)
        // R2 margin high
        `PCR_MARGIN_HIGH: vout_target_o <= regs_ff[`PCR_IDX_MARGIN_UP];
        // R3 margin low
        `PCR_MARGIN_LOW: vout_target_o <= regs_ff[`PCR_IDX_MARGIN_DOWN];
        // nominal command, held under the ceiling
        default: begin
          if (vout_command_i > regs_ff[`PCR_IDX_CEILING]) begin
            vout_target_o <= regs_ff[`PCR_IDX_CEILING];
          end else begin
            vout_target_o <= vout_command_i;
          end
        end
      endcase
      // R18 mode byte decode
      vout_linear_o <= (vout_mode_i[`PCR_MODE_SEL_HI:`PCR_MODE_SEL_LO] == `PCR_MODE_LINEAR);
      vout_exp_o <= vout_mode_i[`PCR_MODE_EXP_HI:`PCR_MODE_EXP_LO];
      // R4 slew rate out
      slew_rate_o <= regs_ff[`PCR_IDX_SLEW];
      // R5 droop slope out
      droop_o <= regs_ff[`PCR_IDX_DROOP];
      // R6 loop gain out
      loop_gain_o <= regs_ff[`PCR_IDX_LOOP_GAIN];
      // R7 divider ratio out
      mon_ratio_o <= regs_ff[`PCR_IDX_MON_RATIO];
      // compared as decoded values, not raw words
      // R8 duty limiting
      if (duty_req_fix > duty_lim_fix) begin
        duty_o <= regs_ff[`PCR_IDX_DUTY];
      end else begin
        duty_o <= duty_request_i;
      end
      // negative settings give zero, fractions are dropped
      // R9 whole kHz frequency
      if (freq_fix < 48'sd0) begin
        switch_khz_o <= 16'h0000;
      end else begin
        switch_khz_o <= freq_fix[31:16];
      end
      // enable follows the hysteresis state
      convert_en_o <= running_ff;
      // bits 15:12 are kept in storage but drive nothing
      // R12 phase fields out
      // R13 group identifier
      group_id_o <= regs_ff[`PCR_IDX_PHASE][`PCR_GROUP_HI:`PCR_GROUP_LO];
      // R14 rail count
      rail_count_o <= regs_ff[`PCR_IDX_PHASE][`PCR_COUNT_HI:`PCR_COUNT_LO];
      // R15 host-set position
      rail_pos_o <= regs_ff[`PCR_IDX_PHASE][`PCR_POS_HI:`PCR_POS_LO];
      // delayed one cycle like every other output
      // R16 offset passthrough
      cs_offset_o <= cs_offset_i;
      // raw unsigned compare in the output voltage format
      // R17 overvoltage compare
      ov_fault_o <= (vout_sense_i > regs_ff[`PCR_IDX_OV_LIMIT]);
    end
  end

endmodule // pcr_config_regs

// ---- common/pcr_consts.vh ----
// Contract
// R1 - ceiling word at 0x24, clamped 110% of strap
// R2 - margin-up target at 0x25 drives margin high
// R3 - margin-down target at 0x26 drives margin low
// R4 - slew rate word at 0x27, V/ms
// R5 - droop slope word at 0x28, mV/A
// R6 - loop sense gain at 0x29, direct
// R7 - monitor divider ratio at 0x2a, direct
// R8 - duty ceiling at 0x32 limits duty
// R9 - switching frequency at 0x33, 1 kHz steps
// R10 - start converting when input reaches start threshold
// R11 - stop converting when input falls to stop threshold
// R12 - phase spread word at 0x37 sets phase
// R13 - bits 11:8 hold group identifier
// R14 - bits 7:4 hold rail count
// R15 - host sets position, sync driver gets 0; the code has no sync driver case and always drives the host-set bits 3:0
// R16 - read-only current sense offset at 0x39
// R17 - overvoltage fault threshold at 0x40
// R18 - mode bits 7:5 000 selects linear exponent
// R19 - linear word: exponent 15:11, mantissa 10:0
// R20 - low byte first; write to offset refused
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH
// command codes
`define PCR_CMD_CEILING 8'h24
`define PCR_CMD_MARGIN_UP 8'h25
`define PCR_CMD_MARGIN_DOWN 8'h26
`define PCR_CMD_SLEW 8'h27
`define PCR_CMD_DROOP 8'h28
`define PCR_CMD_LOOP_GAIN 8'h29
`define PCR_CMD_MON_RATIO 8'h2a
`define PCR_CMD_DUTY 8'h32
`define PCR_CMD_FREQ 8'h33
`define PCR_CMD_VIN_START 8'h35
`define PCR_CMD_VIN_STOP 8'h36
`define PCR_CMD_PHASE 8'h37
`define PCR_CMD_CS_OFFSET 8'h39
`define PCR_CMD_OV_LIMIT 8'h40
// storage indices
`define PCR_IDX_CEILING 4'h0
`define PCR_IDX_MARGIN_UP 4'h1
`define PCR_IDX_MARGIN_DOWN 4'h2
`define PCR_IDX_SLEW 4'h3
`define PCR_IDX_DROOP 4'h4
`define PCR_IDX_LOOP_GAIN 4'h5
`define PCR_IDX_MON_RATIO 4'h6
`define PCR_IDX_DUTY 4'h7
`define PCR_IDX_FREQ 4'h8
`define PCR_IDX_VIN_START 4'h9
`define PCR_IDX_VIN_STOP 4'ha
`define PCR_IDX_PHASE 4'hb
`define PCR_IDX_OV_LIMIT 4'hc
`define PCR_NUM_REGS 13
// reset value of every writable word
`define PCR_RESET_WORD 16'h0000
// phase spread field positions
`define PCR_GROUP_HI 11
`define PCR_GROUP_LO 8
`define PCR_COUNT_HI 7
`define PCR_COUNT_LO 4
`define PCR_POS_HI 3
`define PCR_POS_LO 0
// output voltage mode byte
`define PCR_MODE_SEL_HI 7
`define PCR_MODE_SEL_LO 5
`define PCR_MODE_LINEAR 3'h0
`define PCR_MODE_EXP_HI 4
`define PCR_MODE_EXP_LO 0
// ceiling limit ratio, percent
`define PCR_CEIL_PCT_NUM 20'h0006e
`define PCR_CEIL_PCT_DEN 20'h00064
// margin selection codes
`define PCR_MARGIN_NONE 2'h0
`define PCR_MARGIN_HIGH 2'h1
`define PCR_MARGIN_LOW 2'h2
`endif

// ---- tb/pcr_config_regs_sva.sv ----
`timescale 1ns/1ns
module pcr_cfg_chk (
  // clock and reset
  input wire clock_i,
  input wire rstn_i,
  // byte port
  input wire txn_start_i,
  input wire [7:0] cmd_i,
  input wire wr_byte_valid_i,
  input wire rd_byte_req_i,
  input wire rd_byte_valid_o,
  input wire cmd_known_o,
  input wire wr_refused_o,
  // side values
  input wire [7:0] vout_mode_i,
  input wire [15:0] cs_offset_i,
  input wire [15:0] cs_offset_o,
  input wire vout_linear_o,
  input wire [4:0] vout_exp_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // command phase naming the read-only offset
  sequence s_off_start;
    txn_start_i && cmd_i == 8'h39;
  endsequence
  // low then high byte, back to back
  sequence s_two_bytes;
    (wr_byte_valid_i && !txn_start_i) [*2];
  endsequence
  a_offset_write_refused: assert property (s_off_start ##1 s_two_bytes |=> wr_refused_o)
    else $error("offset write not refused");
  a_refuse_has_cause: assert property (wr_refused_o |-> $past(wr_byte_valid_i))
    else $error("refusal without a byte");
  a_read_answer_next: assert property (rd_byte_req_i && !txn_start_i && !wr_byte_valid_i
    |=> rd_byte_valid_o)
    else $error("read byte not answered next cycle");
  a_valid_has_cause: assert property (rd_byte_valid_o |-> $past(rd_byte_req_i))
    else $error("read valid without request");
  a_offset_cmd_known: assert property (s_off_start |=> cmd_known_o)
    else $error("offset command not known");
  a_unmapped_unknown: assert property (txn_start_i && cmd_i == 8'h30 |=> !cmd_known_o)
    else $error("unmapped command known");
  a_offset_follows: assert property ($past(rstn_i) |-> cs_offset_o == $past(cs_offset_i))
    else $error("offset output not following");
  a_mode_decode: assert property ($past(rstn_i) |-> vout_exp_o == $past(vout_mode_i[4:0])
    && vout_linear_o == ($past(vout_mode_i[7:5]) == 3'h0))
    else $error("mode byte decode wrong");
endmodule // pcr_cfg_chk
bind pcr_config_regs pcr_cfg_chk chk_u (.*);

// ---- tb/pcr_host_model.sv ----
`timescale 1ns/1ns
module pcr_host_model (
  // clock
  input wire clock_i,
  // requests toward the device
  output reg txn_start_o,
  output reg [7:0] cmd_o,
  output reg wr_valid_o,
  output reg [7:0] wr_byte_o,
  output reg rd_req_o,
  // read answer
  input wire [7:0] rd_byte_i,
  input wire rd_valid_i
);
  // idle bus at time zero
  initial begin
    {txn_start_o, wr_valid_o, rd_req_o} = 3'h0;
    {cmd_o, wr_byte_o} = 16'h0000;
  end
  // command phase; idle lines then show the inverse
  task open(input [7:0] c);
    @(negedge clock_i);
    txn_start_o = 1'b1;
    cmd_o = c;
    @(negedge clock_i);
    txn_start_o = 1'b0;
    cmd_o = ~c;
  endtask
  task wr_word(input [7:0] c, input [15:0] w);
    open(c);
    wr_valid_o = 1'b1;
    wr_byte_o = w[7:0];
    @(negedge clock_i);
    wr_byte_o = w[15:8];
    @(negedge clock_i);
    wr_valid_o = 1'b0;
    wr_byte_o = ~w[15:8];
  endtask
  // wait a bounded time for one answered byte
  task get(output [7:0] b, output ok);
    integer n;
    ok = 1'b0;
    for (n = 0; n < 3 && !ok; n++) begin
      @(negedge clock_i);
      if (rd_valid_i === 1'b1) begin
        b = rd_byte_i;
        ok = 1'b1;
      end
    end
  endtask
  // word read, low byte first, requests back to back
  task rd_word(input [7:0] c, output [15:0] w, output ok);
    logic k;
    open(c);
    rd_req_o = 1'b1;
    get(w[7:0], ok);
    get(w[15:8], k);
    rd_req_o = 1'b0;
    ok = ok & k;
  endtask
endmodule // pcr_host_model

// ---- tb/test_pcr_config_regs.sv ----
`timescale 1ns/1ns
`include "pcr_consts.vh"
module test_pcr_config_regs;
  logic clock_i, rstn_i, txn_start_i, wr_byte_valid_i, rd_byte_req_i, rd_byte_valid_o;
  logic cmd_known_o, wr_refused_o, vout_linear_o, convert_en_o, ov_fault_o;
  logic [7:0] cmd_i, wr_byte_i, rd_byte_o, vout_mode_i;
  logic [1:0] margin_sel_i;
  logic [4:0] vout_exp_o;
  logic [3:0] group_id_o, rail_count_o, rail_pos_o;
  logic [15:0] strap_nominal_i, vout_command_i, vin_i, duty_request_i, vout_sense_i;
  logic [15:0] cs_offset_i, vout_target_o, slew_rate_o, droop_o, loop_gain_o, mon_ratio_o;
  logic [15:0] duty_o, switch_khz_o, cs_offset_o, w;
  int fails = 0;
  int samples_checked = 0;
  pcr_config_regs dut_u (.*);
  pcr_host_model host_u (.clock_i(clock_i), .txn_start_o(txn_start_i), .cmd_o(cmd_i),
    .wr_valid_o(wr_byte_valid_i), .wr_byte_o(wr_byte_i), .rd_req_o(rd_byte_req_i),
    .rd_byte_i(rd_byte_o), .rd_valid_i(rd_byte_valid_o));
  // 20 mhz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task tally_and_finish;
    $display("mismatches %0d of %0d checks", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // word read; a missing answer ends the run
  task rd(input [7:0] c);
    logic ok;
    host_u.rd_word(c, w, ok);
    if (!ok) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task settle;
    repeat (3) @(negedge clock_i);
  endtask
  // every writable word except the ceiling: reset value, then readback
  task t_regs;
    logic [7:0] c [12] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h32, 8'h33,
      8'h35, 8'h36, 8'h37, 8'h40};
    for (int i = 0; i < 12; i++) begin
      rd(c[i]);
      chk("reset word", w, 16'h0000);
      host_u.wr_word(c[i], {c[i], ~c[i]});
      rd(c[i]);
      chk("readback", w, {c[i], ~c[i]});
    end
    settle;
    chk("slew", slew_rate_o, 16'h27d8);
    chk("droop", droop_o, 16'h28d7);
    chk("loop gain", loop_gain_o, 16'h29d6);
    chk("monitor ratio", mon_ratio_o, 16'h2ad5);
    chk("group", group_id_o, 16'h0007);
    chk("count", rail_count_o, 16'h000c);
    chk("position", rail_pos_o, 16'h0008);
  endtask
  // ceiling clamp at 110 percent of 0x1000, then margins
  task t_ceiling;
    rd(8'h24);
    chk("ceiling reset", w, 16'h0000);
    host_u.wr_word(8'h24, 16'hffff);
    rd(8'h24);
    chk("ceiling clamp", w, 16'h1199);
    host_u.wr_word(8'h24, 16'h0800);
    vout_command_i = 16'hffff;
    vout_mode_i = 8'h40;
    settle;
    chk("nominal clamp", vout_target_o, 16'h0800);
    margin_sel_i = `PCR_MARGIN_HIGH;
    settle;
    chk("margin high", vout_target_o, 16'h25da);
    margin_sel_i = `PCR_MARGIN_LOW;
    settle;
    chk("margin low", vout_target_o, 16'h26d9);
    margin_sel_i = 2'h3;
    settle;
    chk("code three nominal", vout_target_o, 16'h0800);
  endtask
  // read-only offset and an unmapped command
  task t_refuse;
    host_u.wr_word(8'h39, 16'h1234);
    rd(8'h39);
    chk("offset", w, 16'ha55a);
    host_u.wr_word(8'h30, 16'hffff);
    rd(8'h30);
    chk("unmapped", w, 16'h0000);
  endtask
  // fault threshold boundary, frequency and duty ceiling
  task t_limits;
    vout_sense_i = 16'h40bf;
    host_u.wr_word(8'h33, 16'h012c);
    host_u.wr_word(8'h32, 16'h0020);
    settle;
    chk("ov at limit", ov_fault_o, 16'h0000);
    chk("frequency", switch_khz_o, 16'h012c);
    chk("duty low", duty_o, 16'h0010);
    vout_sense_i = 16'h40c0;
    duty_request_i = 16'h0040;
    settle;
    chk("ov above", ov_fault_o, 16'h0001);
    chk("duty capped", duty_o, 16'h0020);
    host_u.wr_word(8'h33, 16'hf9f4);
    settle;
    chk("frequency half steps", switch_khz_o, 16'h00fa);
    host_u.wr_word(8'h33, 16'h0600);
    settle;
    chk("frequency negative", switch_khz_o, 16'h0000);
  endtask
  // start and stop thresholds with hysteresis
  task t_convert;
    logic [15:0] v [5] = '{16'h0040, 16'h00c0, 16'h0100, 16'h00c0, 16'h0080};
    logic e [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    host_u.wr_word(8'h35, 16'h0100);
    host_u.wr_word(8'h36, 16'h0080);
    for (int i = 0; i < 5; i++) begin
      vin_i = v[i];
      settle;
      chk("convert", convert_en_o, e[i]);
    end
  endtask
  // second reset with a higher strap; the limit must not wrap
  task t_strap;
    rstn_i = 1'b0;
    strap_nominal_i = 16'h9000;
    repeat (2) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rd(8'h24);
    chk("ceiling after reset", w, 16'h0000);
    host_u.wr_word(8'h24, 16'hffff);
    rd(8'h24);
    chk("ceiling wide clamp", w, 16'h9e66);
  endtask
  // main sequence
  initial begin
    rstn_i = 1'b0;
    {strap_nominal_i, vout_command_i, cs_offset_i} = {16'h1000, 16'h0100, 16'ha55a};
    {vin_i, duty_request_i, vout_sense_i} = {16'h00c0, 16'h0010, 16'h0000};
    vout_mode_i = 8'h1c;
    margin_sel_i = `PCR_MARGIN_NONE;
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clock_i);
    t_regs;
    t_ceiling;
    t_refuse;
    t_limits;
    t_convert;
    t_strap;
    tally_and_finish;
  end
endmodule // test_pcr_config_regs
